// ### logic/qsr_read_ctrl.sv
`timescale 1ns/1ps
// How it works
// R1: The block is always the link controller and drives serial clock and chip select itself.
// R2: Read data arrives on one, two or four lanes as the lane mode selects, capped by what the pin count can carry.
// R3: One accepted read request runs the whole command, address and data sequence unaided.
// R4: The serial clock comes from the system clock through a programmable divider.
// R5: Each word is from 1 to 128 bits long as programmed.
// R6: Each frame holds from 1 to 4096 words as programmed.
// R7: The pins are run as a 3-, 4- or 6-pin interface as programmed.
// R8: Optional pulses mark the end of each word and the end of the whole frame.
// R9: Zero to three extra idle serial clock periods follow chip select before clocking.
// R10: The serial clock idles low and data is set up before the first rising edge.
// R11: Read data is sampled on falling serial clock edges, the last bit included.
// R12: The memory launches its data on falling edges, which falling-edge sampling relies on.
// R13: Chip select goes active the delay field plus one periods before the first falling edge.
// R14: Chip select goes inactive two periods after the last falling edge.
// R15: In single-lane mode commands go out on lane zero and data returns on lane one, or on lane zero on a 3-pin link.
module qsr_read_ctrl (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire qsr_pkg::qsr_cfg_t cfg_in,
    input wire logic req_valid_in,
    input wire logic [qsr_pkg::ADDR_W-1:0] req_addr_in,
    output logic req_ready_out,
    output qsr_pkg::qsr_word_t word_out,
    output logic word_irq_out,
    output logic frame_irq_out,
    output logic busy_out,
    input wire logic [3:0] d_in,
    output qsr_pkg::qsr_pins_t pins_out
);
    import qsr_pkg::*;

    // Lane count as log2, limited by what the pin count can carry.
    function automatic logic [1:0] lane_shift(input logic [1:0] pins, input logic [1:0] lanes);
        logic [1:0] sh;
        sh = 2'h0;
        if (pins == PINS_6 && lanes == LANE_QUAD) begin
            sh = 2'h2; // R7
        end else if (pins != PINS_3 && lanes != LANE_SINGLE) begin
            sh = 2'h1; // R7
        end
        return sh;
    endfunction

    qsr_state_t state_q;
    qsr_cfg_t cfg_q;
    logic [3:0] d_meta_q;
    logic [3:0] d_sync_q;
    logic tick;
    logic fall;
    logic sclk_q;
    logic cs_n_q;
    logic [2:0] half_cnt_q;
    logic [5:0] hdr_idx_q;
    logic [HDR_W-1:0] hdr_sh_q;
    logic [WLEN_W-1:0] clk_in_word_q;
    logic [WCNT_W-1:0] word_idx_q;
    logic [WORD_MAX+3:0] rx_sh_q;
    logic [WORD_MAX+3:0] rx_next;
    logic [3:0] lane_bits;
    logic [1:0] sh;
    logic [WLEN_W-1:0] clocks_m1;
    logic [7:0] extra;
    logic word_end;
    logic [3:0] oe_n;
    qsr_word_t word_q;
    logic word_irq_q;
    logic frame_irq_q;

    // Pin data crosses in from outside, so it passes two flip-flops first.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            d_meta_q <= 4'h0;
            d_sync_q <= 4'h0;
        end else begin
            d_meta_q <= d_in;
            d_sync_q <= d_meta_q;
        end
    end

    qsr_sclk_div u_div (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .run_in(state_q != ST_IDLE),
        .div_in(cfg_q.clk_div),
        .tick_out(tick)
    ); // R4

    // Derived per-frame values.
    assign sh = lane_shift(cfg_q.pin_mode, cfg_q.lane_mode); // R2
    assign clocks_m1 = cfg_q.word_len_m1 >> sh; // R5
    assign fall = tick && sclk_q && (state_q == ST_CMD || state_q == ST_READ);
    assign word_end = (clk_in_word_q == clocks_m1);

    // Lane one carries single-lane data on a 4- or 6-pin link, lane zero on a 3-pin link.
    always_comb begin
        lane_bits = 4'h0;
        case (sh)
            2'h2: lane_bits = d_sync_q; // R2
            2'h1: lane_bits = {2'h0, d_sync_q[1:0]}; // R2
            default: lane_bits = {3'h0, (cfg_q.pin_mode == PINS_3) ? d_sync_q[0] : d_sync_q[1]}; // R15
        endcase
    end

    // Shifted value and the number of padding bits when length is not a lane multiple.
    always_comb begin
        rx_next = (rx_sh_q << (1 << sh)) | {{WORD_MAX{1'b0}}, lane_bits};
        extra = 8'(((({1'b0, clocks_m1}) + 8'h01) << sh) - ({1'b0, cfg_q.word_len_m1} + 8'h01));
    end

    // Frame sequencing.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (req_valid_in) begin
                        state_q <= ST_LEAD; // R3
                    end
                end
                ST_LEAD: begin
                    if (tick && half_cnt_q == {cfg_q.select_to_clock_delay_field, 1'b0}) begin
                        state_q <= ST_CMD; // R9
                    end
                end
                ST_CMD: begin
                    if (fall && hdr_idx_q == HDR_LAST) begin
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (fall && word_end && word_idx_q == cfg_q.word_cnt_m1) begin
                        state_q <= ST_TRAIL; // R6
                    end
                end
                ST_TRAIL: begin
                    if (tick && half_cnt_q == TRAIL_HALVES - 3'h1) begin
                        state_q <= ST_IDLE; // R14
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Configuration is frozen per frame so a change mid-frame cannot tear a word.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q <= '0;
        end else if (state_q == ST_IDLE && req_valid_in) begin
            cfg_q <= cfg_in;
        end
    end

    // Half-period counter for the lead-in and trailing gaps around clocking.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            half_cnt_q <= 3'h0;
        end else if (state_q != ST_LEAD && state_q != ST_TRAIL) begin
            half_cnt_q <= 3'h0;
        end else if (tick) begin
            half_cnt_q <= half_cnt_q + 3'h1;
        end
    end

    // Serial clock idles low; the first rise lands one half period before the first fall.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_q <= SCLK_IDLE;
        end else if (state_q == ST_LEAD && state_q != ST_IDLE && tick &&
                     half_cnt_q == {cfg_q.select_to_clock_delay_field, 1'b0}) begin
            sclk_q <= 1'b1; // R13
        end else if (state_q == ST_READ && fall && word_end &&
                     word_idx_q == cfg_q.word_cnt_m1) begin
            sclk_q <= SCLK_IDLE; // R10
        end else if (tick && (state_q == ST_CMD || state_q == ST_READ)) begin
            sclk_q <= ~sclk_q; // R10
        end else if (state_q == ST_IDLE || state_q == ST_TRAIL) begin
            sclk_q <= SCLK_IDLE; // R10
        end
    end

    // Chip select spans the whole frame including the lead-in and trailing gaps.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_n_q <= CS_N_IDLE;
        end else if (state_q == ST_IDLE && req_valid_in) begin
            cs_n_q <= 1'b0; // R1
        end else if (state_q == ST_TRAIL && tick && half_cnt_q == TRAIL_HALVES - 3'h1) begin
            cs_n_q <= CS_N_IDLE; // R14
        end
    end

    // Command and address leave MSB first on lane zero, changing on falling edges.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hdr_sh_q <= '0;
            hdr_idx_q <= 6'h00;
        end else if (state_q == ST_IDLE && req_valid_in) begin
            hdr_sh_q <= {cfg_in.read_cmd, req_addr_in}; // R15
            hdr_idx_q <= 6'h00;
        end else if (fall && state_q == ST_CMD) begin
            hdr_sh_q <= {hdr_sh_q[HDR_W-2:0], 1'b0}; // R10
            hdr_idx_q <= hdr_idx_q + 6'h01;
        end
    end

    // Receive path: sample on every falling edge of the data phase.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_sh_q <= '0;
            clk_in_word_q <= '0;
            word_idx_q <= '0;
        end else if (state_q == ST_IDLE) begin
            rx_sh_q <= '0;
            clk_in_word_q <= '0;
            word_idx_q <= '0;
        end else if (fall && state_q == ST_READ) begin
            rx_sh_q <= word_end ? '0 : rx_next; // R11
            clk_in_word_q <= word_end ? '0 : clk_in_word_q + 7'h01; // R5
            if (word_end) begin
                word_idx_q <= word_idx_q + 12'h001; // R6
            end
        end
    end

    // Completed words and their optional completion pulses.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_q <= '0;
            word_irq_q <= 1'b0;
            frame_irq_q <= 1'b0;
        end else begin
            word_q.valid <= 1'b0;
            word_q.last <= 1'b0;
            word_irq_q <= 1'b0;
            frame_irq_q <= 1'b0;
            if (fall && state_q == ST_READ && word_end) begin
                word_q.data <= WORD_MAX'(rx_next >> extra); // R11
                word_q.valid <= 1'b1;
                word_q.last <= (word_idx_q == cfg_q.word_cnt_m1);
                word_irq_q <= cfg_q.word_irq_en; // R8
                frame_irq_q <= cfg_q.frame_irq_en && (word_idx_q == cfg_q.word_cnt_m1); // R8
            end
        end
    end

    // Drive enables are low-active; the data phase releases every lane to the memory.
    always_comb begin
        oe_n = OE_N_OFF;
        if (!cs_n_q && (state_q == ST_LEAD || state_q == ST_CMD)) begin
            oe_n = 4'he; // R15
        end
    end

    assign req_ready_out = (state_q == ST_IDLE);
    assign busy_out = (state_q != ST_IDLE);
    assign word_out = word_q;
    assign word_irq_out = word_irq_q;
    assign frame_irq_out = frame_irq_q;
    assign pins_out.sclk = sclk_q; // R1
    assign pins_out.cs_n = cs_n_q; // R1
    assign pins_out.d_out = {3'h0, hdr_sh_q[HDR_W-1] & ~cs_n_q};
    assign pins_out.d_oe_n = oe_n;

endmodule // qsr_read_ctrl

// ### logic/qsr_pkg.sv
package qsr_pkg;

    // Clock and serial clock timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_MIN_PERIOD_NS = 25;
    localparam logic [7:0] DIV_MIN = 8'((SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
                                        / (2 * CLK_PERIOD_NS) - 1);
    localparam int TRAIL_PERIODS = 2;
    localparam logic [2:0] TRAIL_HALVES = 3'(2 * TRAIL_PERIODS);

    // Frame geometry.
    localparam int WORD_MAX = 128;
    localparam int WCNT_W = 12;
    localparam int WLEN_W = 7;
    localparam int CMD_W = 8;
    localparam int ADDR_W = 24;
    localparam int HDR_W = CMD_W + ADDR_W;
    localparam logic [5:0] HDR_LAST = 6'(HDR_W - 1);

    // Lane mode encodings.
    localparam logic [1:0] LANE_SINGLE = 2'h0;
    localparam logic [1:0] LANE_DUAL = 2'h1;
    localparam logic [1:0] LANE_QUAD = 2'h2;

    // Pin count encodings.
    localparam logic [1:0] PINS_3 = 2'h0;
    localparam logic [1:0] PINS_4 = 2'h1;
    localparam logic [1:0] PINS_6 = 2'h2;

    // Reset values of the pins.
    localparam logic CS_N_IDLE = 1'b1;
    localparam logic SCLK_IDLE = 1'b0;
    localparam logic [3:0] OE_N_OFF = 4'hf;

    typedef struct packed {
        logic [7:0] clk_div;
        logic [1:0] lane_mode;
        logic [1:0] pin_mode;
        logic [WLEN_W-1:0] word_len_m1;
        logic [WCNT_W-1:0] word_cnt_m1;
        logic [1:0] select_to_clock_delay_field;
        logic [CMD_W-1:0] read_cmd;
        logic word_irq_en;
        logic frame_irq_en;
    } qsr_cfg_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic [3:0] d_out;
        logic [3:0] d_oe_n;
    } qsr_pins_t;

    typedef struct packed {
        logic [WORD_MAX-1:0] data;
        logic valid;
        logic last;
    } qsr_word_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LEAD = 5'h02,
        ST_CMD = 5'h04,
        ST_READ = 5'h08,
        ST_TRAIL = 5'h10
    } qsr_state_t;

endpackage

// ### logic/qsr_sclk_div.sv
`timescale 1ns/1ps
module qsr_sclk_div (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic [7:0] div_in,
    output logic tick_out
);
    import qsr_pkg::*;

    logic [7:0] cnt_q;
    logic [7:0] div_eff;

    // Clamp the ratio so the serial clock never runs faster than its minimum period.
    assign div_eff = (div_in < DIV_MIN) ? DIV_MIN : div_in;
    assign tick_out = run_in && (cnt_q == div_eff);

    // Half-period counter; it restarts while idle so every frame starts in phase.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 8'h00;
        end else if (!run_in || tick_out) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

endmodule // qsr_sclk_div

// ### sim/qsr_read_ctrl_assertions.sv
`timescale 1ns/1ps
module qsr_read_ctrl_assertions (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire qsr_pkg::qsr_cfg_t cfg_in,
    input wire logic req_valid_in,
    input wire logic [qsr_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic req_ready_out,
    input wire qsr_pkg::qsr_word_t word_out,
    input wire logic word_irq_out,
    input wire logic frame_irq_out,
    input wire logic busy_out,
    input wire logic [3:0] d_in,
    input wire qsr_pkg::qsr_pins_t pins_out
);
    import qsr_pkg::*;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic [3:0] low_q;
    // Low clock cycles inside a frame; it saturates so a long tail cannot wrap to zero.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_q <= 4'h0;
        end else if (pins_out.sclk || pins_out.cs_n) begin
            low_q <= 4'h0;
        end else if (low_q != 4'hf) begin
            low_q <= low_q + 4'h1;
        end
    end
    chk_ready_idle: assert property ((req_ready_out == !busy_out) && (pins_out.cs_n || busy_out))
        else $error("ready and busy disagree");
    chk_take_select: assert property (req_valid_in && req_ready_out |=> !pins_out.cs_n)
        else $error("select not taken after request");
    chk_clock_idle: assert property (pins_out.cs_n |-> !pins_out.sclk)
        else $error("clock high while deselected");
    chk_lines_free: assert property (pins_out.cs_n && !busy_out |-> pins_out.d_oe_n == OE_N_OFF)
        else $error("data line driven while idle");
    chk_lead_low: assert property ($fell(pins_out.cs_n) |-> !pins_out.sclk [*2])
        else $error("clock too soon after select");
    chk_half_period: assert property ($rose(pins_out.sclk) |-> pins_out.sclk [*2])
        else $error("clock high phase too short");
    chk_trail_gap: assert property ($rose(pins_out.cs_n) |-> low_q >= 4'h7)
        else $error("select released too early");
    chk_valid_pulse: assert property (word_out.valid |=> !word_out.valid)
        else $error("word valid longer than one cycle");
    chk_frame_last: assert property (frame_irq_out |-> word_out.last && word_out.valid)
        else $error("frame pulse without last word");
    chk_word_fall: assert property (word_out.valid |-> !pins_out.cs_n && !pins_out.sclk)
        else $error("word outside a low clock phase");
    cover property (frame_irq_out);
    cover property (word_irq_out && word_out.valid);
    cover property ($rose(pins_out.cs_n));
endmodule // qsr_read_ctrl_assertions

// ### sim/qsr_flash_model.sv
`timescale 1ns/1ps
module qsr_flash_model (
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic d0_in,
    input wire logic [3:0] seed_in,
    output logic [3:0] d_out,
    output logic [31:0] hdr_out
);
    int falls = 0;
    initial d_out = 4'h0;
    initial hdr_out = 32'h0;
    // Command and address are taken on rising edges, as clock mode zero expects.
    always @(posedge sclk_in) begin
        if (!cs_n_in && falls < 32) hdr_out <= {hdr_out[30:0], d0_in};
    end
    // Data leaves on falling edges; once deselected the lines flip so stale data never matches.
    always @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            falls = 0;
            d_out <= ~d_out;
        end else begin
            falls = falls + 1;
            if (falls >= 32) d_out <= seed_in + 4'(3 * (falls - 32));
        end
    end
endmodule // qsr_flash_model

// ### sim/qsr_read_ctrl_bench.sv
`timescale 1ns/1ps
module qsr_read_ctrl_bench;
    import qsr_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    qsr_cfg_t cfg = '0;
    logic req_valid = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic req_ready, word_irq, frame_irq, busy;
    qsr_word_t word;
    qsr_pins_t pins;
    logic [3:0] d_in, mem_d, seed = 4'h0;
    logic [31:0] hdr, rs = 32'hc;
    int num_errors = 0, num_checks = 0, lanes, len, sel, i;
    localparam int CFG_W = $bits(qsr_cfg_t);
    always #5 clk_sys_in = ~clk_sys_in;
    // Each line carries the controller where it drives and the memory elsewhere.
    assign d_in = (~pins.d_oe_n & pins.d_out) | (pins.d_oe_n & mem_d);
    qsr_read_ctrl dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cfg_in(cfg),
        .req_valid_in(req_valid), .req_addr_in(addr), .req_ready_out(req_ready),
        .word_out(word), .word_irq_out(word_irq), .frame_irq_out(frame_irq),
        .busy_out(busy), .d_in(d_in), .pins_out(pins));
    qsr_flash_model mem (.sclk_in(pins.sclk), .cs_n_in(pins.cs_n), .d0_in(d_in[0]),
        .seed_in(seed), .d_out(mem_d), .hdr_out(hdr));
    function logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // A word is the next len bits of the lane stream, first bit highest, surplus dropped.
    function automatic logic [127:0] exp_word(int w);
        logic [127:0] r = '0;
        logic [3:0] p;
        int n = 0, b, k;
        k = w * ((len + lanes - 1) / lanes);
        while (n < len) begin
            p = seed + 4'(3 * k);
            for (b = lanes - 1; b >= 0 && n < len; b--) begin
                r = {r[126:0], (lanes == 1) ? p[sel] : p[b]};
                n++;
            end
            k++;
        end
        return r;
    endfunction
    task chk_val(logic [127:0] got, logic [127:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_num(int got, int exp);
        chk_val(128'(got), 128'(exp));
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Runs one frame; the settings are scrambled once taken, since they must be captured.
    task automatic run_frame();
        int t, t_cs = -1, t_f1 = -1, t_lf = -1, t_csr = -1, w = 0;
        int d = int'(cfg.select_to_clock_delay_field);
        int h = (cfg.clk_div == 8'h0 ? 1 : int'(cfg.clk_div)) + 1;
        int cnt = int'(cfg.word_cnt_m1);
        logic wie = cfg.word_irq_en, fie = cfg.frame_irq_en, ps = 1'b0, stuck;
        logic [31:0] hx = {cfg.read_cmd, addr};
        // Three pins carry one lane only, and four lanes need all six pins.
        lanes = (cfg.pin_mode == PINS_3) ? 1 :
            (cfg.lane_mode == LANE_QUAD && cfg.pin_mode == PINS_6) ? 4 :
            (cfg.lane_mode == LANE_SINGLE) ? 1 : 2;
        len = int'(cfg.word_len_m1) + 1;
        sel = (cfg.pin_mode == PINS_3) ? 0 : 1;
        req_valid = 1'b1;
        for (t = 0; t < 100 && req_ready !== 1'b1; t++) @(negedge clk_sys_in);
        // A controller that never becomes ready skips the frame and ends as a timeout.
        stuck = (req_ready !== 1'b1);
        @(negedge clk_sys_in);
        req_valid = 1'b0;
        cfg = qsr_cfg_t'(CFG_W'({rnd(), rnd()}));
        addr = 24'(rnd());
        for (t = 0; t < 40000 && t_csr < 0 && !stuck; t++) begin
            if (t == 0) chk_val(128'({busy, req_ready}), 128'(2'b10));
            if (pins.cs_n === 1'b0 && t_cs < 0) t_cs = t;
            if (ps === 1'b1 && pins.sclk === 1'b0) begin
                if (t_f1 < 0) t_f1 = t;
                t_lf = t;
            end
            ps = pins.sclk;
            if (word.valid === 1'b1) begin
                chk_val(word.data, exp_word(w));
                chk_val(128'({word.last, word_irq, frame_irq}), 128'({w == cnt, wie, fie && w == cnt}));
                w++;
            end
            if (t_cs >= 0 && pins.cs_n === 1'b1) t_csr = t;
            @(negedge clk_sys_in);
        end
        if (t_csr < 0) begin
            num_errors++;
            complete_run();
        end else begin
            chk_num(w, cnt + 1);
            chk_val(128'({busy, req_ready}), 128'(2'b01));
            chk_num(t_f1 - t_cs, (2 * d + 2) * h);
            chk_num(t_csr - t_lf, 4 * h);
            chk_val(128'(hdr), 128'(hx));
            $display("frame done: lanes %0d bits %0d words %0d", lanes, len, w);
        end
    endtask
    // Corner frames first: one bit, full 128 bits, and 4096 one-bit words; the rest random.
    // The last two frames ask for more lanes than their pin count can carry.
    initial begin
        repeat (6) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        chk_val(128'({pins, req_ready}), 128'({SCLK_IDLE, CS_N_IDLE, 4'h0, OE_N_OFF, 1'b1}));
        for (i = 0; i < 11; i++) begin
            cfg.lane_mode = (i == 9) ? LANE_QUAD : (i == 10) ? LANE_DUAL : 2'(i % 3);
            cfg.pin_mode = (i == 9) ? PINS_4 : (i == 10) ? PINS_3 :
                (i % 3 == 2) ? PINS_6 : (i % 3 == 1) ? 2'(1 + i % 2) : 2'(i / 3);
            cfg.word_len_m1 = (i == 1) ? 7'h7f : (i == 0 || i == 2) ? 7'h0 : 7'(rnd());
            cfg.word_cnt_m1 = (i == 2) ? 12'hfff : 12'(rnd() % 4);
            cfg.select_to_clock_delay_field = 2'(i);
            cfg.clk_div = (i < 3) ? 8'h0 : 8'(rnd() % 4);
            cfg.read_cmd = 8'(rnd());
            {cfg.word_irq_en, cfg.frame_irq_en} = 2'(i);
            addr = 24'(rnd());
            seed = 4'(rnd());
            run_frame();
        end
        complete_run();
    end
endmodule // qsr_read_ctrl_bench
bind qsr_read_ctrl qsr_read_ctrl_assertions chk (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .cfg_in(cfg_in), .req_valid_in(req_valid_in),
    .req_addr_in(req_addr_in), .req_ready_out(req_ready_out), .word_out(word_out),
    .word_irq_out(word_irq_out), .frame_irq_out(frame_irq_out), .busy_out(busy_out),
    .d_in(d_in), .pins_out(pins_out));
